// >>> dv/acd_asserts.sv
/*
  Checker on the decoder top ports: reset values, exclusive modes, done flag, pump pin, serial enable.
  Assumes one core_clk domain; cs_n is only sampled on core_clk here.
*/
module acd_asserts
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       cs_n,
  input wire logic       sdo_oe,
  input wire logic [3:0] latch_outputs,
  input wire logic       chop_rate_select,
  input wire logic       reduced_power,
  input wire logic [2:0] word_rate_sel,
  input wire logic       unipolar,
  input wire logic [2:0] range_select,
  input wire logic       port_flag_mode,
  input wire logic       pump_drive_pin_out,
  input wire logic       pump_drive_pin_oe,
  input wire logic       converting,
  input wire logic       calibrating,
  input wire logic       standby_mode,
  input wire logic       sleep_mode,
  input wire logic       done_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [13:0] cfg_pins;
  logic [3:0]  idle_cyc;
  assign cfg_pins = {latch_outputs, chop_rate_select, reduced_power, word_rate_sel, unipolar, range_select,
                     port_flag_mode};
  // settings move only through frames, so count core cycles since cs_n was last low
  always_ff @(posedge core_clk)
    if (!rst_n || !cs_n)
      idle_cyc <= 4'h0;
    else if (idle_cyc != 4'hF)
      idle_cyc <= idle_cyc + 4'h1;
  default clocking ck @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_sleep_held;
    sleep_mode [*2];
  endsequence
  sequence s_pump_parked;
    !pump_drive_pin_oe [*2];
  endsequence
  a_reset_values: assert property ($rose(rst_n) |-> cfg_pins == 14'h0000 && !done_flag)
    else $error("settings not at reset value");
  a_modes_exclusive: assert property (!(standby_mode && sleep_mode) && !(converting && calibrating))
    else $error("two modes at once");
  a_sleep_pump: assert property (s_sleep_held |-> !pump_drive_pin_oe)
    else $error("pump driven in sleep");
  a_pump_parked: assert property (s_pump_parked |-> !pump_drive_pin_out)
    else $error("pump toggles while floated");
  a_sdo_released: assert property (cs_n && $past(cs_n) |-> !sdo_oe)
    else $error("sdo driven outside frame");
  a_done_cleared: assert property ($rose(converting) |-> !done_flag)
    else $error("done left set at start");
  a_done_cause: assert property ($rose(done_flag) |-> converting || calibrating)
    else $error("done without a cycle");
  a_done_restart: assert property ($fell(done_flag) |=> converting || calibrating)
    else $error("done cleared without start");
  a_cfg_framed: assert property ($changed(cfg_pins) |-> idle_cyc < 4'h8)
    else $error("settings moved outside a frame");
endmodule : acd_asserts

bind acd_top acd_asserts u_acd_asserts
(
  .core_clk, .rst_n, .cs_n, .sdo_oe, .latch_outputs, .chop_rate_select, .reduced_power, .word_rate_sel,
  .unipolar, .range_select, .port_flag_mode, .pump_drive_pin_out, .pump_drive_pin_oe, .converting,
  .calibrating, .standby_mode, .sleep_mode, .done_flag
);

// >>> dv/acd_host.sv
/*
  Host model on the three-wire port: frames of command and data bits, MSB first, 30 ns serial clock.
  Assumes the device shifts sdo after each rising edge; the clock stands low between frames.
*/
module acd_host
(
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b1;
  end
  // sends n bits from the top of v; every sample taken on a falling edge is shifted into r
  task xfer(input logic [79:0] v, input int n, output logic [79:0] r);
    r = '0;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      sdi = v[79 - i];
      #15 sclk = 1'b1;
      #15 r = {r[78:0], sdo & sdo_oe};
      sclk = 1'b0;
    end
    #15 cs_n = 1'b1;
    // a released line must not keep showing its last bit
    sdi = ~sdi;
    #15;
  endtask : xfer
endmodule : acd_host

// >>> dv/adc_command_config_decoder_bench.sv
/*
  Self-checking bench of the command decoder: register access, group transfer, conversions,
  calibrations and power save, all through the serial host model.
  Assumes acd_top, acd_host and the checker bind are compiled first.
*/
module adc_command_config_decoder_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import acd_pkg::*;
  logic        core_clk, rst_n, osc_clock_in, sclk, cs_n, sdi, sdo, sdo_oe, done_flag;
  logic        chop_rate_select, reduced_power, unipolar, port_flag_mode, pump_drive_pin_out, pump_drive_pin_oe;
  logic        converting, calibrating, standby_mode, sleep_mode;
  logic [3:0]  latch_outputs;
  logic [2:0]  word_rate_sel, range_select;
  acd_word_t   conv_result, got;
  logic [79:0] rx;
  int          err_count, checks_done, n;
  logic [2:0]  cal_codes [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6};

  acd_top DUT (.core_clk, .rst_n, .sclk, .cs_n, .sdi, .osc_clock_in, .conv_result, .sdo, .sdo_oe, .latch_outputs,
    .chop_rate_select, .reduced_power, .word_rate_sel, .unipolar, .range_select, .port_flag_mode,
    .pump_drive_pin_out, .pump_drive_pin_oe, .converting, .calibrating, .standby_mode, .sleep_mode, .done_flag);
  acd_host host (.sclk, .cs_n, .sdi, .sdo, .sdo_oe);

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // oscillator at 250 ns keeps a 162-period conversion near 1620 core cycles
  initial
  begin
    osc_clock_in = 1'b0;
    forever #125 osc_clock_in = ~osc_clock_in;
  end

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task chk_word(input acd_word_t g, input acd_word_t e, input string m);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk_word
  task chk_bit(input logic g, input logic e, input string m);
    chk_word({23'h0, g}, {23'h0, e}, m);
  endtask : chk_bit
  task wait_cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : wait_cyc
  task rd(input logic [7:0] c, output acd_word_t w);
    host.xfer({c, 72'h0}, 32, rx);
    w = rx[24:1];
    wait_cyc(12);
  endtask : rd
  task wr(input logic [7:0] c, input acd_word_t w);
    host.xfer({c, w, 48'h0}, 32, rx);
    wait_cyc(12);
  endtask : wr
  task rdc(input logic [7:0] c, input acd_word_t e, input string m);
    rd(c, got);
    chk_word(got, e, m);
  endtask : rdc
  task wait_done;
    n = 0;
    while (done_flag !== 1'b1 && n < 5000)
    begin
      @(posedge core_clk);
      n++;
    end
    #1;
  endtask : wait_done

  task t_reset_vals;
    chk_word({20'h0, latch_outputs}, 24'h0, "latch");
    chk_bit(pump_drive_pin_oe, 1'b1, "pump");
    got[0] = pump_drive_pin_out;
    wait_cyc(10);
    chk_bit(pump_drive_pin_out, !got[0], "pump toggle");
    rdc(8'h94, 24'h000040, "cfg");
    rdc(8'h94, 24'h000000, "cfg reread");
    rdc(8'h90, 24'h000000, "offset");
    rdc(8'h92, 24'h800000, "gain");
  endtask : t_reset_vals
  task t_cfg_fields;
    wr(8'h84, 24'hA5BB30);
    chk_word({10'h0, latch_outputs, chop_rate_select, reduced_power, word_rate_sel, unipolar, range_select,
      port_flag_mode}, 24'h002BBB, "pins");
    chk_bit(pump_drive_pin_oe, 1'b0, "pump off");
    rdc(8'h94, 24'hA5BB30, "cfg");
    host.xfer({8'h00, 8'h94, 64'h0}, 40, rx);
    wait_cyc(12);
    chk_word(rx[24:1], 24'hA5BB30, "after null");
    wr(8'h84, 24'h000000);
    chk_bit(pump_drive_pin_oe, 1'b1, "pump on");
  endtask : t_cfg_fields
  task t_setup;
    host.xfer({8'h88, 24'h123456, 24'h654321, 24'h500000}, 80, rx);
    wait_cyc(12);
    rdc(8'h90, 24'h123456, "offset");
    rdc(8'h92, 24'h654321, "gain");
    chk_word({20'h0, latch_outputs}, 24'h5, "latch");
    host.xfer({8'h98, 72'h0}, 80, rx);
    wait_cyc(12);
    chk_word(rx[72:49], 24'h123456, "group offset");
    chk_word(rx[48:25], 24'h654321, "group gain");
    chk_word(rx[24:1], 24'h500000, "group cfg");
    wr(8'h86, 24'hFFFFFF);
    rdc(8'h96, 24'h000000, "data");
  endtask : t_setup
  task t_reset_req;
    wr(8'h84, 24'h000080);
    chk_word({20'h0, latch_outputs}, 24'h0, "latch");
    wr(8'h80, 24'h111111);
    wr(8'h84, 24'h000000);
    rdc(8'h94, 24'h000040, "cfg");
    rdc(8'h94, 24'h000000, "cfg reread");
    rdc(8'h90, 24'h000000, "offset");
    rdc(8'h92, 24'h800000, "gain");
  endtask : t_reset_req
  task t_convert;
    wr(8'h84, 24'h00A000);
    rd(8'hD6, got);
    wait_done();
    chk_bit(n inside {[1540:1640]}, 1'b1, "conv length");
    wait_cyc(4);
    chk_bit(converting, 1'b0, "single");
    rdc(8'h96, 24'h0ABCDE, "data");
    rdc(8'h94, 24'h00A008, "done bit");
    rd(8'hB6, got);
    wait_cyc(3500);
    chk_bit(converting, 1'b1, "repeat");
    chk_bit(done_flag, 1'b1, "repeat done");
    rd(8'h97, got);
    chk_bit(standby_mode, 1'b1, "standby");
    chk_bit(converting, 1'b0, "stopped");
    rd(8'h96, got);
    chk_bit(standby_mode, 1'b0, "run");
    wr(8'h84, 24'h00A010);
    rd(8'h97, got);
    chk_bit(sleep_mode, 1'b1, "sleep");
    chk_bit(pump_drive_pin_oe, 1'b0, "sleep pump");
    rd(8'h96, got);
    chk_bit(sleep_mode, 1'b0, "wake");
  endtask : t_convert
  task t_calib;
    foreach (cal_codes[k])
    begin
      @(posedge core_clk) conv_result <= {8'h3C, 13'h0, cal_codes[k]};
      wr(8'h84, {21'h001400, cal_codes[k]});
      rd(8'hD6, got);
      chk_bit(calibrating, 1'b1, "calibrating");
      wait_done();
      chk_bit(done_flag, 1'b1, "cal done");
      rdc(8'h94, 24'h00A008, "cal cleared");
      rdc(cal_codes[k] inside {3'h2, 3'h3, 3'h6} ? 8'h92 : 8'h90, {8'h3C, 13'h0, cal_codes[k]}, "cal word");
    end
  endtask : t_calib

  initial
  begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    $display("unexpected at %0t: watchdog", $time);
    close_out();
  end
  initial
  begin
    rst_n = 1'b0;
    conv_result = 24'h0ABCDE;
    err_count = 0;
    checks_done = 0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    wait_cyc(4);
    t_reset_vals();
    t_cfg_fields();
    t_setup();
    t_reset_req();
    t_convert();
    t_calib();
    close_out();
  end
endmodule : adc_command_config_decoder_bench

// >>> inc/acd_link_if.sv
/*
  Crossing bundle between the core-clock decoder and the serial-clock port logic.
  Assumes every toggle is resynchronised by the receiver and held words are stable
  for many receiver cycles around each toggle.
*/
interface acd_link_if;
  import acd_pkg::*;

  logic           link_rst;
  acd_word_t      img [4];
  logic           cmd_tgl;
  logic [7:0]     cmd_hold;
  logic           wr_tgl;
  acd_word_t      wr_word;
  logic [1:0]     wr_tgt;
  logic           cfg_rd_tgl;

  modport core
  (
    output link_rst,
    output img,
    input  cmd_tgl,
    input  cmd_hold,
    input  wr_tgl,
    input  wr_word,
    input  wr_tgt,
    input  cfg_rd_tgl
  );

  modport link
  (
    input  link_rst,
    input  img,
    output cmd_tgl,
    output cmd_hold,
    output wr_tgl,
    output wr_word,
    output wr_tgt,
    output cfg_rd_tgl
  );
endinterface : acd_link_if

// >>> inc/acd_map.svh
/*
  Constant map of the ADC command and configuration decoder: command bit positions,
  register select codes, configuration fields, reset values and word-rate periods.
  Assumes it is included by bare name from files that already import acd_pkg.
*/
`ifndef ACD_MAP_SVH
`define ACD_MAP_SVH

`define ACD_CMD_EXEC      7
`define ACD_CMD_ONCE      6
`define ACD_CMD_REPEAT    5
`define ACD_CMD_READ      4
`define ACD_CMD_SEL_HI    3
`define ACD_CMD_SEL_LO    1
`define ACD_CMD_PSAVE     0

`define ACD_SEL_OFFSET    3'h0
`define ACD_SEL_GAIN      3'h1
`define ACD_SEL_CFG       3'h2
`define ACD_SEL_DATA      3'h3
`define ACD_SEL_SETUP     3'h4

`define ACD_TGT_OFFSET    2'h0
`define ACD_TGT_GAIN      2'h1
`define ACD_TGT_CFG       2'h2
`define ACD_TGT_DATA      2'h3

`define ACD_CFG_LATCH_HI  23
`define ACD_CFG_LATCH_LO  20
`define ACD_CFG_CHOP      18
`define ACD_CFG_LOWPWR    16
`define ACD_CFG_WR_HI     15
`define ACD_CFG_WR_LO     13
`define ACD_CFG_UNIPOLAR  12
`define ACD_CFG_RANGE_HI  11
`define ACD_CFG_RANGE_LO  9
`define ACD_CFG_PUMP_OFF  8
`define ACD_CFG_RST_REQ   7
`define ACD_CFG_RST_SEEN  6
`define ACD_CFG_PFLAG     5
`define ACD_CFG_SLEEP     4
`define ACD_CFG_DONE      3
`define ACD_CFG_CAL_HI    2
`define ACD_CFG_CAL_LO    0

`define ACD_CFG_RESET     24'h000040
`define ACD_OFFSET_RESET  24'h000000
`define ACD_GAIN_RESET    24'h800000
`define ACD_CFG_WMASK     24'hF5FFB7

`define ACD_CMD_LAST      5'h07
`define ACD_WORD_LAST     5'h17
`define ACD_SETUP_LAST    2'h2

`define ACD_WR_CYC0       14'h0886
`define ACD_WR_CYC1       14'h0442
`define ACD_WR_CYC2       14'h0222
`define ACD_WR_CYC3       14'h010A
`define ACD_WR_CYC4       14'h00C2
`define ACD_WR_CYC5       14'h00A2
`define ACD_WR_CYC6       14'h2212
`define ACD_WR_CYC7       14'h110A

`define ACD_CAL_NONE      3'h0
`define ACD_CAL_OFS_SELF  3'h1
`define ACD_CAL_GAIN_SELF 3'h2
`define ACD_CAL_BOTH_SELF 3'h3
`define ACD_CAL_OFS_SYS   3'h5
`define ACD_CAL_GAIN_SYS  3'h6

`endif

// >>> inc/acd_pkg.sv
/*
  Types of the ADC command and configuration decoder.
  Assumes nothing beyond a SystemVerilog compiler; constants live in acd_map.svh.
*/
package acd_pkg;

  typedef logic [23:0] acd_word_t;
  typedef logic [13:0] acd_period_t;

  typedef enum logic [1:0]
  {
    ACD_IDLE,
    ACD_CONVERT,
    ACD_CALIB,
    ACD_SAVE
  } acd_state_e;

endpackage : acd_pkg

// >>> rtl/acd_link.sv
/*
  Serial port on the serial clock: command mode, data mode, word shifting.
  Assumes sdi is stable at sclk rising edges, cs_n high ends any frame, and the
  data image from the core is frozen while a frame is active, the config image changing only after writes; offset and gain are live.
*/
`include "acd_map.svh"

module acd_link
(
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sdi,
  output logic      sdo,
  output logic      sdo_oe,
  acd_link_if.link  lk
);
  import acd_pkg::*;

  logic [4:0] bit_cnt;
  logic       in_data;
  logic [7:0] cmd;
  acd_word_t  shreg;
  logic [1:0] word_idx;
  logic [7:0] next_cmd;
  logic       cmd_done;
  logic       word_end;
  logic       more_words;
  logic       cfg_load;

  function automatic logic [1:0] target(input logic [2:0] sel, input logic [1:0] idx);
    target = (sel == `ACD_SEL_SETUP) ? idx : sel[1:0];
  endfunction : target

  assign next_cmd   = {cmd[6:0], sdi};
  assign cmd_done   = !in_data && (bit_cnt == `ACD_CMD_LAST) && next_cmd[`ACD_CMD_EXEC];
  assign word_end   = in_data && (bit_cnt == `ACD_WORD_LAST);
  assign more_words = (cmd[`ACD_CMD_SEL_HI:`ACD_CMD_SEL_LO] == `ACD_SEL_SETUP) && (word_idx != `ACD_SETUP_LAST);
  // reading config is what clears the reset-seen flag in the core
  assign cfg_load   = (cmd_done && next_cmd[`ACD_CMD_READ]
                       && target(next_cmd[3:1], 2'h0) == `ACD_TGT_CFG)
                    || (word_end && cmd[`ACD_CMD_READ] && more_words
                       && target(cmd[3:1], word_idx + 2'h1) == `ACD_TGT_CFG);
  assign sdo = shreg[23];

  // frame state is cleared by cs_n itself, since sclk may stop between frames;
  // the core reset clears it too, so the port never wakes up outside command mode
  always_ff @(posedge sclk or posedge cs_n or posedge lk.link_rst)
  begin
    if (cs_n || lk.link_rst)
    begin
      bit_cnt  <= 5'h00;
      in_data  <= 1'b0;
      cmd      <= 8'h00;
      word_idx <= 2'h0;
      shreg    <= 24'h000000;
      sdo_oe   <= 1'b0;
    end
    else if (!in_data)
    begin
      cmd <= next_cmd;
      if (bit_cnt == `ACD_CMD_LAST)
      begin
        bit_cnt <= 5'h00;
        if (next_cmd[`ACD_CMD_EXEC])
        begin
          in_data  <= 1'b1;
          word_idx <= 2'h0;
          sdo_oe   <= next_cmd[`ACD_CMD_READ];
          shreg    <= lk.img[target(next_cmd[3:1], 2'h0)];
        end
      end
      else
        bit_cnt <= bit_cnt + 5'h01;
    end
    else if (word_end)
    begin
      bit_cnt <= 5'h00;
      if (more_words)
      begin
        word_idx <= word_idx + 2'h1;
        shreg    <= lk.img[target(cmd[3:1], word_idx + 2'h1)];
      end
      else
      begin
        in_data <= 1'b0;
        sdo_oe  <= 1'b0;
      end
    end
    else
    begin
      bit_cnt <= bit_cnt + 5'h01;
      shreg   <= {shreg[22:0], sdi};
    end
  end

  always_ff @(posedge sclk or posedge lk.link_rst)
  begin
    if (lk.link_rst)
    begin
      lk.cmd_tgl    <= 1'b0;
      lk.cmd_hold   <= 8'h00;
      lk.wr_tgl     <= 1'b0;
      lk.wr_word    <= 24'h000000;
      lk.wr_tgt     <= 2'h0;
      lk.cfg_rd_tgl <= 1'b0;
    end
    else if (!cs_n)
    begin
      if (cmd_done)
      begin
        lk.cmd_hold <= next_cmd;
        lk.cmd_tgl  <= !lk.cmd_tgl;
      end
      if (word_end && !cmd[`ACD_CMD_READ])
      begin
        lk.wr_word <= {shreg[22:0], sdi};
        lk.wr_tgt  <= target(cmd[3:1], word_idx);
        lk.wr_tgl  <= !lk.wr_tgl;
      end
      if (cfg_load)
        lk.cfg_rd_tgl <= !lk.cfg_rd_tgl;
    end
  end
endmodule : acd_link

// >>> rtl/acd_top.sv
/*
  ADC command decoder and configuration register: executes command words, holds the
  offset, gain, configuration and conversion data words, times conversions and
  calibrations on the oscillator clock and drives the latch and pump pins.
  Assumes conv_result comes from core_clk logic; sclk, cs_n, sdi and osc_clock_in are pins.
*/
`include "acd_map.svh"

module acd_top
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              sdi,
  input  wire logic              osc_clock_in,
  input  wire acd_pkg::acd_word_t conv_result,
  output logic                   sdo,
  output logic                   sdo_oe,
  output logic [3:0]             latch_outputs,
  output logic                   chop_rate_select,
  output logic                   reduced_power,
  output logic [2:0]             word_rate_sel,
  output logic                   unipolar,
  output logic [2:0]             range_select,
  output logic                   port_flag_mode,
  output logic                   pump_drive_pin_out,
  output logic                   pump_drive_pin_oe,
  output logic                   converting,
  output logic                   calibrating,
  output logic                   standby_mode,
  output logic                   sleep_mode,
  output logic                   done_flag
);
  import acd_pkg::*;

  acd_link_if lk ();

  acd_word_t   cfg;
  acd_word_t   offset;
  acd_word_t   gain;
  acd_word_t   data;
  acd_word_t   cfg_img;
  acd_word_t   data_img;
  acd_state_e  state;
  logic        repeat_on;
  logic        cal_phase;
  acd_period_t osc_cnt;
  logic        cs_s1;
  logic        cs_s2;
  logic        osc_s1;
  logic        osc_s2;
  logic        osc_s3;
  logic        osc_tick;
  logic [2:0]  ev_s1;
  logic [2:0]  ev_s2;
  logic [2:0]  ev_s3;
  logic [2:0]  ev_pulse;
  logic        cmd_ev;
  logic        wr_ev;
  logic        cfg_rd_ev;
  logic        wr_seen;
  logic [7:0]  cmd_word;
  logic        held;
  logic        sys_reset_ev;
  logic        start_ev;
  logic        cycle_end;
  logic        conv_end;
  logic        cal_end;
  logic        cal_mid;
  logic [2:0]  cal_code;
  acd_word_t   next_cfg;

  function automatic acd_period_t period_of(input logic [2:0] rate);
    case (rate)
      3'h0:    period_of = `ACD_WR_CYC0;
      3'h1:    period_of = `ACD_WR_CYC1;
      3'h2:    period_of = `ACD_WR_CYC2;
      3'h3:    period_of = `ACD_WR_CYC3;
      3'h4:    period_of = `ACD_WR_CYC4;
      3'h5:    period_of = `ACD_WR_CYC5;
      3'h6:    period_of = `ACD_WR_CYC6;
      default: period_of = `ACD_WR_CYC7;
    endcase
  endfunction : period_of

  function automatic logic cal_hits_offset(input logic [2:0] code, input logic phase);
    cal_hits_offset = (code == `ACD_CAL_OFS_SELF) || (code == `ACD_CAL_OFS_SYS)
                   || ((code == `ACD_CAL_BOTH_SELF) && !phase);
  endfunction : cal_hits_offset

  function automatic logic cal_hits_gain(input logic [2:0] code, input logic phase);
    cal_hits_gain = (code == `ACD_CAL_GAIN_SELF) || (code == `ACD_CAL_GAIN_SYS)
                 || ((code == `ACD_CAL_BOTH_SELF) && phase);
  endfunction : cal_hits_gain

  acd_link u_link
  (
    .sclk   (sclk),
    .cs_n   (cs_n),
    .sdi    (sdi),
    .sdo    (sdo),
    .sdo_oe (sdo_oe),
    .lk     (lk.link)
  );

  // data reads see a frame-frozen copy, config reads one refreshed after writes, so a mid-frame conversion cannot tear a word; offset and gain are live
  assign lk.img[0] = offset;
  assign lk.img[1] = gain;
  assign lk.img[2] = cfg_img;
  assign lk.img[3] = data_img;

  always_ff @(posedge core_clk)
  begin
    lk.link_rst <= !rst_n;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      ev_s1  <= 3'h0;
      ev_s2  <= 3'h0;
      ev_s3  <= 3'h0;
    end
    else
    begin
      cs_s1  <= cs_n;
      cs_s2  <= cs_s1;
      osc_s1 <= osc_clock_in;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      ev_s1  <= {lk.cfg_rd_tgl, lk.wr_tgl, lk.cmd_tgl};
      ev_s2  <= ev_s1;
      ev_s3  <= ev_s2;
    end
  end

  assign osc_tick  = osc_s2 && !osc_s3;
  assign ev_pulse  = ev_s2 ^ ev_s3;
  assign cmd_ev    = ev_pulse[0];
  assign wr_ev     = ev_pulse[1];
  assign cfg_rd_ev = ev_pulse[2];
  // held words are stable for many core cycles after their toggle is seen
  assign cmd_word  = lk.cmd_hold;

  assign held         = cfg[`ACD_CFG_RST_REQ];
  assign sys_reset_ev = wr_ev && (lk.wr_tgt == `ACD_TGT_CFG) && !held
                        && lk.wr_word[`ACD_CFG_RST_REQ];
  assign start_ev     = cmd_ev && !held && !cmd_word[`ACD_CMD_PSAVE]
                        && (cmd_word[`ACD_CMD_ONCE] || cmd_word[`ACD_CMD_REPEAT]);
  assign cal_code     = cfg[`ACD_CFG_CAL_HI:`ACD_CFG_CAL_LO];
  assign cycle_end    = osc_tick && (osc_cnt == period_of(word_rate_sel) - 14'h0001);
  assign conv_end     = (state == ACD_CONVERT) && cycle_end;
  assign cal_mid      = (state == ACD_CALIB) && cycle_end
                        && (cal_code == `ACD_CAL_BOTH_SELF) && !cal_phase;
  assign cal_end      = (state == ACD_CALIB) && cycle_end && !cal_mid;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state     <= ACD_IDLE;
      repeat_on <= 1'b0;
      cal_phase <= 1'b0;
    end
    else if (held || sys_reset_ev)
    begin
      state     <= ACD_IDLE;
      repeat_on <= 1'b0;
      cal_phase <= 1'b0;
    end
    else if (cmd_ev && cmd_word[`ACD_CMD_PSAVE])
    begin
      state     <= ACD_SAVE;
      repeat_on <= 1'b0;
    end
    else if (start_ev)
    begin
      repeat_on <= cmd_word[`ACD_CMD_REPEAT];
      cal_phase <= 1'b0;
      state     <= (cal_code != `ACD_CAL_NONE) ? ACD_CALIB : ACD_CONVERT;
    end
    else
    begin
      case (state)
        ACD_SAVE:
        begin
          if (cmd_ev)
            state <= ACD_IDLE;
        end
        ACD_CONVERT:
        begin
          if (conv_end && !repeat_on)
            state <= ACD_IDLE;
        end
        ACD_CALIB:
        begin
          if (cal_mid)
            cal_phase <= 1'b1;
          else if (cal_end)
            state <= repeat_on ? ACD_CONVERT : ACD_IDLE;
        end
        ACD_IDLE:
          state <= ACD_IDLE;
        default:
          state <= ACD_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || start_ev || cycle_end || cal_mid)
      osc_cnt <= 14'h0000;
    else if (osc_tick && (state == ACD_CONVERT || state == ACD_CALIB))
      osc_cnt <= osc_cnt + 14'h0001;
  end

  always_comb
  begin
    next_cfg = cfg;
    if (wr_ev && lk.wr_tgt == `ACD_TGT_CFG)
    begin
      if (held)
        next_cfg[`ACD_CFG_RST_REQ] = lk.wr_word[`ACD_CFG_RST_REQ];
      else if (lk.wr_word[`ACD_CFG_RST_REQ])
        next_cfg = `ACD_CFG_RESET | (24'h000001 << `ACD_CFG_RST_REQ);
      else
        next_cfg = (lk.wr_word & `ACD_CFG_WMASK) | (cfg & ~`ACD_CFG_WMASK);
    end
    if (cal_end)
      next_cfg[`ACD_CFG_CAL_HI:`ACD_CFG_CAL_LO] = `ACD_CAL_NONE;
    if (start_ev)
      next_cfg[`ACD_CFG_DONE] = 1'b0;
    if (conv_end || cal_end)
      next_cfg[`ACD_CFG_DONE] = 1'b1;
    if (cfg_rd_ev && !held)
      next_cfg[`ACD_CFG_RST_SEEN] = 1'b0;
    if (next_cfg[`ACD_CFG_RST_REQ])
      next_cfg[`ACD_CFG_RST_SEEN] = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      cfg <= `ACD_CFG_RESET;
    else
      cfg <= next_cfg;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || sys_reset_ev)
    begin
      offset <= `ACD_OFFSET_RESET;
      gain   <= `ACD_GAIN_RESET;
    end
    else if (wr_ev && !held)
    begin
      if (lk.wr_tgt == `ACD_TGT_OFFSET)
        offset <= lk.wr_word;
      if (lk.wr_tgt == `ACD_TGT_GAIN)
        gain <= lk.wr_word;
    end
    else if ((cal_mid || cal_end) && cal_hits_offset(cal_code, cal_phase))
      offset <= conv_result;
    else if (cal_end && cal_hits_gain(cal_code, cal_phase))
      gain <= conv_result;
  end

  // writes aimed at the data register never reach it
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      data <= 24'h000000;
    else if (conv_end)
      data <= conv_result;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wr_seen  <= 1'b0;
      cfg_img  <= `ACD_CFG_RESET;
      data_img <= 24'h000000;
    end
    else
    begin
      wr_seen <= wr_ev;
      if (cs_s2 || wr_seen)
        cfg_img <= cfg;
      if (cs_s2)
        data_img <= data;
    end
  end

  assign latch_outputs    = cfg[`ACD_CFG_LATCH_HI:`ACD_CFG_LATCH_LO];
  assign chop_rate_select = cfg[`ACD_CFG_CHOP];
  assign reduced_power    = cfg[`ACD_CFG_LOWPWR];
  assign word_rate_sel    = cfg[`ACD_CFG_WR_HI:`ACD_CFG_WR_LO];
  assign unipolar         = cfg[`ACD_CFG_UNIPOLAR];
  assign range_select     = cfg[`ACD_CFG_RANGE_HI:`ACD_CFG_RANGE_LO];
  assign port_flag_mode   = cfg[`ACD_CFG_PFLAG];
  assign done_flag        = cfg[`ACD_CFG_DONE];

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      converting   <= 1'b0;
      calibrating  <= 1'b0;
      standby_mode <= 1'b0;
      sleep_mode   <= 1'b0;
    end
    else
    begin
      converting   <= (state == ACD_CONVERT);
      calibrating  <= (state == ACD_CALIB);
      standby_mode <= (state == ACD_SAVE) && !cfg[`ACD_CFG_SLEEP];
      sleep_mode   <= (state == ACD_SAVE) && cfg[`ACD_CFG_SLEEP];
    end
  end

  // pump drive runs off the oscillator; asleep, sleep_mode holds the pump low and floated
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pump_drive_pin_out <= 1'b0;
      pump_drive_pin_oe  <= 1'b0;
    end
    else
    begin
      pump_drive_pin_oe <= !cfg[`ACD_CFG_PUMP_OFF] && !sleep_mode;
      if (cfg[`ACD_CFG_PUMP_OFF] || sleep_mode)
        pump_drive_pin_out <= 1'b0;
      else if (osc_tick)
        pump_drive_pin_out <= !pump_drive_pin_out;
    end
  end
endmodule : acd_top
